// [docu_unit.sv]
// docu_unit: data operation unit (compare / add / subtract, 16 or 32 bit)
// assumes a single-cycle register master on CLK_IN and a stop request from power management
//
// Overview of operation
// - size bit selects 16 or 32 bit width
// - compare input with references at width
// - add or subtract input to running value
// - condition codes 0-3: ne, eq, lt, gt
// - code 4 inside range, 5 outside range
// - matched condition requests an interrupt
// - addition carry out sets overflow interrupt
// - subtraction borrow sets underflow interrupt
// - control bit 7 gates interrupt output
// - event pulse on every detection, ungated
// - input register 32 bits, read and write
// - two 32-bit reference registers, read/write
// - module stop blocks register writes and so new operations
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module docu_unit
   import docu_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic [DOCU_ADDR_W-1:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic MODULE_STOP_IN,
   output logic [31:0] RDATA_OUT,
   output logic IRQ_OUT,
   output logic EVENT_OUT
);
   docu_bus_req_t req;
   docu_ctl_t ctl_q;
   logic [31:0] din_q;
   logic [31:0] ref0_q;
   logic [31:0] ref1_q;
   logic [2:0] stat_q;
   logic [2:0] ien_q;
   logic [31:0] rdata_q;
   logic irq_q;
   logic evt_q;
   logic op_go_q;
   logic stop_s1_q;
   logic stop_s2_q;

   assign req = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

   // width masking used for all operands
   function automatic logic [31:0] fit(input logic [31:0] v, input logic wide);
      fit = wide ? v : {16'h0000, v[15:0]};
   endfunction

   wire stopped = stop_s2_q;
   wire wr_ok = req.wr && !stopped;
   wire wr_ctl = wr_ok && (req.addr == DOCU_OFS_CONTROL);
   wire wr_din = wr_ok && (req.addr == DOCU_OFS_INPUT);
   wire wr_ref0 = wr_ok && (req.addr == DOCU_OFS_REF0);
   wire wr_ref1 = wr_ok && (req.addr == DOCU_OFS_REF1);
   wire wr_clr = wr_ok && (req.addr == DOCU_OFS_STAT_CLR);
   wire wr_ien = wr_ok && (req.addr == DOCU_OFS_IRQ_EN);

   // operands at selected width
   wire wide = ctl_q.size32;
   wire [31:0] a = fit(din_q, wide);
   wire [31:0] r0 = fit(ref0_q, wide);
   wire [31:0] r1 = fit(ref1_q, wide);
   wire lt0 = a < r0;
   wire gt0 = a > r0;
   wire gt1 = a > r1;
   wire eq0 = a == r0;
   wire [32:0] sum = {1'b0, r0} + {1'b0, a};
   wire [32:0] dif = {1'b0, r0} - {1'b0, a};
   wire carry = wide ? sum[32] : sum[16];
   wire borrow = dif[32];

   logic cond_hit;
   always_comb begin
      case (ctl_q.cond)
         DOCU_COND_NE: cond_hit = !eq0;
         DOCU_COND_EQ: cond_hit = eq0;
         DOCU_COND_LT: cond_hit = lt0;
         DOCU_COND_GT: cond_hit = gt0;
         DOCU_COND_IN: cond_hit = gt0 && (a < r1);
         DOCU_COND_OUT: cond_hit = lt0 || gt1;
         // reserved codes never fire; software keeps off them
         default: cond_hit = 1'b0;
      endcase
   end

   wire is_cmp = ctl_q.mode == DOCU_MODE_CMP;
   wire is_add = ctl_q.mode == DOCU_MODE_ADD;
   wire is_sub = ctl_q.mode == DOCU_MODE_SUB;
   // evaluation happens the cycle after the input write, on the stored word
   wire ev_match = op_go_q && is_cmp && cond_hit;
   wire ev_ovf = op_go_q && is_add && carry;
   wire ev_unf = op_go_q && is_sub && borrow;
   wire [2:0] ev_vec = {ev_unf, ev_ovf, ev_match};
   wire [31:0] arith_res = fit(is_add ? sum[31:0] : dif[31:0], wide);

   wire [31:0] rd_mux =
      (req.addr == DOCU_OFS_CONTROL) ? {24'h0, ctl_q} :
      (req.addr == DOCU_OFS_INPUT) ? din_q :
      (req.addr == DOCU_OFS_REF0) ? ref0_q :
      (req.addr == DOCU_OFS_REF1) ? ref1_q :
      (req.addr == DOCU_OFS_STATUS) ? {29'h0, stat_q} :
      (req.addr == DOCU_OFS_IRQ_EN) ? {29'h0, ien_q} : 32'h0;

   // sticky: set wins over clear
   wire [2:0] stat_d = ev_vec | (stat_q & ~(wr_clr ? req.wdata[2:0] : 3'h0));
   wire irq_d = ctl_q.irq_en && |(stat_d & ien_q);

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         stop_s1_q <= 1'b0;
         stop_s2_q <= 1'b0;
      end else begin
         stop_s1_q <= MODULE_STOP_IN;
         stop_s2_q <= stop_s1_q;
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ctl_q <= DOCU_CTL_RST;
         ien_q <= DOCU_IEN_RST;
         din_q <= DOCU_WORD_RST;
         ref1_q <= DOCU_WORD_RST;
      end else begin
         if (wr_ctl) ctl_q <= req.wdata[7:0];
         if (wr_ien) ien_q <= req.wdata[2:0];
         if (wr_din) din_q <= req.wdata;
         if (wr_ref1) ref1_q <= req.wdata;
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ref0_q <= DOCU_WORD_RST;
         op_go_q <= 1'b0;
      end else begin
         op_go_q <= wr_din;
         if (wr_ref0) ref0_q <= req.wdata;
         else if (op_go_q && (is_add || is_sub)) ref0_q <= arith_res;
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         stat_q <= DOCU_STAT_RST;
         irq_q <= 1'b0;
         evt_q <= 1'b0;
         rdata_q <= DOCU_WORD_RST;
      end else begin
         stat_q <= stat_d;
         irq_q <= irq_d;
         evt_q <= |ev_vec;
         rdata_q <= req.rd ? rd_mux : 32'h0;
      end
   end

   assign RDATA_OUT = rdata_q;
   assign IRQ_OUT = irq_q;
   assign EVENT_OUT = evt_q;

   property p_event_follows;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (|ev_vec) |=> EVENT_OUT;
   endproperty
   a_event_follows: assert property (p_event_follows) else $error("event missing");

   property p_event_cause;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      EVENT_OUT |-> $past(op_go_q);
   endproperty
   a_event_cause: assert property (p_event_cause) else $error("event without op");

   property p_irq_gate;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      !$past(ctl_q.irq_en) |-> !IRQ_OUT;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");

   sequence s_input_write;
      wr_din ##1 1'b1;
   endsequence
   property p_eval_after_write;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      s_input_write |-> op_go_q;
   endproperty
   a_eval_after_write: assert property (p_eval_after_write) else $error("no eval");

   property p_sticky;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (stat_q[DOCU_ST_MATCH] && !wr_clr) |=> stat_q[DOCU_ST_MATCH];
   endproperty
   a_sticky: assert property (p_sticky) else $error("status lost");

   property p_ovf16;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (op_go_q && is_add && !wide && (({1'b0, r0[15:0]} + {1'b0, a[15:0]}) > 17'h0ffff))
      |=> stat_q[DOCU_ST_OVF] ##0 EVENT_OUT;
   endproperty
   a_ovf16: assert property (p_ovf16) else $error("16-bit overflow missed");

   property p_unf;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (op_go_q && is_sub && (a > r0)) |=> stat_q[DOCU_ST_UNF];
   endproperty
   a_unf: assert property (p_unf) else $error("underflow missed");

   property p_ref0_narrow;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (op_go_q && is_add && !wide && !wr_ref0) |=> (ref0_q[31:16] == 16'h0000);
   endproperty
   a_ref0_narrow: assert property (p_ref0_narrow) else $error("result not truncated");

   property p_stop_holds;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (stopped && req.wr) |=> $stable(ctl_q);
   endproperty
   a_stop_holds: assert property (p_stop_holds) else $error("write during stop");

   sequence s_match_seen;
      stat_q[DOCU_ST_MATCH] ##0 EVENT_OUT;
   endsequence
   sequence s_ovf_seen;
      stat_q[DOCU_ST_OVF] ##0 EVENT_OUT;
   endsequence
   sequence s_unf_seen;
      stat_q[DOCU_ST_UNF] ##0 EVENT_OUT;
   endsequence
   sequence s_cmp_write_hit;
      wr_din ##1 (is_cmp && cond_hit);
   endsequence

   property p_write_to_event;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      s_cmp_write_hit |=> s_match_seen;
   endproperty
   a_write_to_event: assert property (p_write_to_event) else $error("no event");

   property p_ovf32;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (op_go_q && is_add && wide && (({1'b0, ref0_q} + {1'b0, din_q}) > 33'h0_ffff_ffff))
      |=> s_ovf_seen;
   endproperty
   a_ovf32: assert property (p_ovf32) else $error("32-bit overflow missed");

   property p_no_ovf32;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (op_go_q && is_add && wide && (({1'b0, ref0_q} + {1'b0, din_q}) <= 33'h0_ffff_ffff))
      |=> !EVENT_OUT;
   endproperty
   a_no_ovf32: assert property (p_no_ovf32) else $error("false overflow");

   property p_unf16;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (op_go_q && is_sub && !wide && (din_q[15:0] > ref0_q[15:0])) |=> s_unf_seen;
   endproperty
   a_unf16: assert property (p_unf16) else $error("16-bit underflow missed");

   property p_no_unf32;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (op_go_q && is_sub && wide && (din_q <= ref0_q)) |=> !EVENT_OUT;
   endproperty
   a_no_unf32: assert property (p_no_unf32) else $error("false underflow");

   property p_add_sum32;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (op_go_q && is_add && wide && !wr_ref0) |=> (ref0_q == $past(ref0_q) + $past(din_q));
   endproperty
   a_add_sum32: assert property (p_add_sum32) else $error("bad sum");

   property p_sub_diff16;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (op_go_q && is_sub && !wide && !wr_ref0)
      |=> (ref0_q == {16'h0000, 16'($past(ref0_q[15:0]) - $past(din_q[15:0]))});
   endproperty
   a_sub_diff16: assert property (p_sub_diff16) else $error("bad difference");

   property p_mode_keeps_ref0;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (op_go_q && !is_add && !is_sub && !wr_ref0) |=> $stable(ref0_q);
   endproperty
   a_mode_keeps_ref0: assert property (p_mode_keeps_ref0) else $error("ref0 moved");

   property p_eq32;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (op_go_q && is_cmp && wide && (ctl_q.cond == DOCU_COND_EQ) && (din_q == ref0_q))
      |=> s_match_seen;
   endproperty
   a_eq32: assert property (p_eq32) else $error("32-bit match missed");

   property p_ne16_quiet;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (op_go_q && is_cmp && !wide && (ctl_q.cond == DOCU_COND_NE)
         && (din_q[15:0] == ref0_q[15:0])) |=> !EVENT_OUT;
   endproperty
   a_ne16_quiet: assert property (p_ne16_quiet) else $error("false mismatch");

   property p_in_range16;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (op_go_q && is_cmp && !wide && (ctl_q.cond == DOCU_COND_IN)
         && (ref0_q[15:0] < din_q[15:0]) && (din_q[15:0] < ref1_q[15:0]))
      |=> s_match_seen;
   endproperty
   a_in_range16: assert property (p_in_range16) else $error("in range missed");

   property p_out_quiet16;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (op_go_q && is_cmp && !wide && (ctl_q.cond == DOCU_COND_OUT)
         && (din_q[15:0] >= ref0_q[15:0]) && (din_q[15:0] <= ref1_q[15:0]))
      |=> !EVENT_OUT;
   endproperty
   a_out_quiet16: assert property (p_out_quiet16) else $error("false out of range");

   property p_irq_raise;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (ctl_q.irq_en && (|(ev_vec & ien_q))) |=> IRQ_OUT;
   endproperty
   a_irq_raise: assert property (p_irq_raise) else $error("irq missing");

   property p_irq_source;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      IRQ_OUT |-> (|(stat_q & $past(ien_q)));
   endproperty
   a_irq_source: assert property (p_irq_source) else $error("irq without status");

   property p_clear_all;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (wr_clr && (req.wdata[2:0] == 3'h7) && !(|ev_vec))
      |=> ((stat_q == 3'h0) && !IRQ_OUT);
   endproperty
   a_clear_all: assert property (p_clear_all) else $error("status not cleared");

   property p_status_ro;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (wr_ok && (req.addr == DOCU_OFS_STATUS) && !(|ev_vec))
      |=> $stable(stat_q);
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status written");

   property p_read_input;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (req.rd && (req.addr == DOCU_OFS_INPUT)) |=> (RDATA_OUT == $past(din_q));
   endproperty
   a_read_input: assert property (p_read_input) else $error("bad input read");

   property p_stop_no_eval;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (stopped && req.wr) |=> !op_go_q;
   endproperty
   a_stop_no_eval: assert property (p_stop_no_eval) else $error("eval during stop");

   property p_ctl_write;
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      wr_ctl |=> (ctl_q == $past(req.wdata[7:0]));
   endproperty
   a_ctl_write: assert property (p_ctl_write) else $error("control not written");
endmodule

// [docu_pkg.sv]
// docu_pkg: register map, field positions and types for the data operation unit
// assumes a plain single-cycle register port, 32-bit data, word index addressing
package docu_pkg;
   localparam int DOCU_ADDR_W = 4;
   // register indices (word address)
   localparam logic [3:0] DOCU_OFS_CONTROL = 4'h0;
   localparam logic [3:0] DOCU_OFS_INPUT = 4'h1;
   localparam logic [3:0] DOCU_OFS_REF0 = 4'h2;
   localparam logic [3:0] DOCU_OFS_REF1 = 4'h3;
   localparam logic [3:0] DOCU_OFS_STATUS = 4'h4;
   localparam logic [3:0] DOCU_OFS_STAT_CLR = 4'h5;
   localparam logic [3:0] DOCU_OFS_IRQ_EN = 4'h6;
   // control field positions
   localparam int DOCU_CTL_MODE_LO = 0;
   localparam int DOCU_CTL_SIZE_BIT = 3;
   localparam int DOCU_CTL_COND_LO = 4;
   localparam int DOCU_CTL_IRQE_BIT = 7;
   // reset values
   localparam logic [7:0] DOCU_CTL_RST = 8'h00;
   localparam logic [31:0] DOCU_WORD_RST = 32'h0000_0000;
   localparam logic [2:0] DOCU_STAT_RST = 3'h0;
   localparam logic [2:0] DOCU_IEN_RST = 3'h7;
   // status bit positions
   localparam int DOCU_ST_MATCH = 0;
   localparam int DOCU_ST_OVF = 1;
   localparam int DOCU_ST_UNF = 2;
   // operation modes in control bits 1:0
   typedef enum logic [1:0] {
      DOCU_MODE_CMP = 2'h0,
      DOCU_MODE_ADD = 2'h1,
      DOCU_MODE_SUB = 2'h2,
      DOCU_MODE_RSV = 2'h3
   } docu_mode_t;
   // detection conditions
   typedef enum logic [2:0] {
      DOCU_COND_NE = 3'h0,
      DOCU_COND_EQ = 3'h1,
      DOCU_COND_LT = 3'h2,
      DOCU_COND_GT = 3'h3,
      DOCU_COND_IN = 3'h4,
      DOCU_COND_OUT = 3'h5
   } docu_cond_t;
   typedef struct packed {
      logic irq_en;
      logic [2:0] cond;
      logic size32;
      logic rsv;
      logic [1:0] mode;
   } docu_ctl_t;
   typedef struct packed {
      logic [DOCU_ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } docu_bus_req_t;
endpackage

// [docu_unit_test.sv]
// docu_unit_test: self-checking bench for the data operation unit
// assumes docu_pkg and docu_unit are compiled first; assertions live in the design
`timescale 1ns/10ps
module docu_unit_test;
   import docu_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic stop = 1'b0;
   logic [DOCU_ADDR_W-1:0] addr = '0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic irq;
   logic ev;
   int errors = 0;
   int compares = 0;
   docu_unit dut_u (.CLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
      .WR_IN(wr), .RD_IN(rd), .MODULE_STOP_IN(stop), .RDATA_OUT(rdata), .IRQ_OUT(irq),
      .EVENT_OUT(ev));
   always #2.5 clk = ~clk;
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data only stand in the cycle after the strobe
   task automatic rreg(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("read data", rdata, exp);
   endtask
   // input write, then event and irq one edge after the strobe is taken
   task automatic fire(input logic [31:0] d, input logic e, input logic i);
      wreg(DOCU_OFS_INPUT, d);
      @(posedge clk);
      #1;
      chk("event", {31'h0, ev}, {31'h0, e});
      chk("irq", {31'h0, irq}, {31'h0, i});
   endtask
   task automatic t_reset;
      rreg(DOCU_OFS_CONTROL, 32'h0000_0000);
      rreg(DOCU_OFS_REF0, 32'h0000_0000);
      rreg(DOCU_OFS_IRQ_EN, 32'h0000_0007);
      rreg(4'hf, 32'h0000_0000);
      wreg(DOCU_OFS_STATUS, 32'h0000_0007);
      rreg(DOCU_OFS_STATUS, 32'h0000_0000);
      wreg(DOCU_OFS_REF1, 32'ha5c3_0f1e);
      rreg(DOCU_OFS_REF1, 32'ha5c3_0f1e);
   endtask
   task automatic t_compare;
      logic [5:0] hit [3];
      logic [31:0] din [3];
      hit = '{6'b100101, 6'b000010, 6'b011001};
      din = '{32'h0000_0005, 32'h0001_000a, 32'h0000_000f};
      wreg(DOCU_OFS_REF0, 32'h0000_000a);
      wreg(DOCU_OFS_REF1, 32'h0000_0014);
      for (int c = 0; c < 6; c++) begin
         wreg(DOCU_OFS_CONTROL, {24'h0, 1'b1, 3'(c), 4'h0});
         for (int k = 0; k < 3; k++) begin
            // upper half of 2nd word is ignored at 16 bits
            fire(din[k], hit[k][c], hit[k][c]);
            rreg(DOCU_OFS_STATUS, {31'h0, hit[k][c]});
            rreg(DOCU_OFS_INPUT, din[k]);
            wreg(DOCU_OFS_STAT_CLR, 32'h0000_0007);
         end
      end
      // 32-bit equality sees the upper half
      wreg(DOCU_OFS_CONTROL, 32'h0000_0098);
      fire(32'h0001_000a, 1'b0, 1'b0);
      fire(32'h0000_000a, 1'b1, 1'b1);
      rreg(DOCU_OFS_STATUS, 32'h0000_0001);
      wreg(DOCU_OFS_STAT_CLR, 32'h0000_0007);
   endtask
   task automatic t_arith;
      wreg(DOCU_OFS_CONTROL, 32'h0000_0081);
      wreg(DOCU_OFS_REF0, 32'h0000_ffff);
      fire(32'h0000_0001, 1'b1, 1'b1);
      rreg(DOCU_OFS_REF0, 32'h0000_0000);
      rreg(DOCU_OFS_STATUS, 32'h0000_0002);
      wreg(DOCU_OFS_STAT_CLR, 32'h0000_0007);
      wreg(DOCU_OFS_CONTROL, 32'h0000_0089);
      wreg(DOCU_OFS_REF0, 32'hffff_fffe);
      fire(32'h0000_0001, 1'b0, 1'b0);
      fire(32'h0000_0001, 1'b1, 1'b1);
      rreg(DOCU_OFS_REF0, 32'h0000_0000);
      wreg(DOCU_OFS_STAT_CLR, 32'h0000_0007);
      wreg(DOCU_OFS_CONTROL, 32'h0000_0082);
      wreg(DOCU_OFS_REF0, 32'h0000_0000);
      fire(32'h0000_0001, 1'b1, 1'b1);
      rreg(DOCU_OFS_REF0, 32'h0000_ffff);
      rreg(DOCU_OFS_STATUS, 32'h0000_0004);
      wreg(DOCU_OFS_STAT_CLR, 32'h0000_0007);
      wreg(DOCU_OFS_CONTROL, 32'h0000_008a);
      wreg(DOCU_OFS_REF0, 32'h0000_0005);
      fire(32'h0000_0005, 1'b0, 1'b0);
      fire(32'h0000_0001, 1'b1, 1'b1);
      rreg(DOCU_OFS_REF0, 32'hffff_ffff);
      wreg(DOCU_OFS_STAT_CLR, 32'h0000_0007);
      // idle mode code: no event, running value untouched
      wreg(DOCU_OFS_CONTROL, 32'h0000_008b);
      fire(32'h0000_0001, 1'b0, 1'b0);
      rreg(DOCU_OFS_REF0, 32'hffff_ffff);
   endtask
   // enable bit and per-bit mask both hold the line down
   task automatic t_gate;
      wreg(DOCU_OFS_CONTROL, 32'h0000_0010);
      wreg(DOCU_OFS_REF0, 32'h0000_000a);
      fire(32'h0000_000a, 1'b1, 1'b0);
      wreg(DOCU_OFS_IRQ_EN, 32'h0000_0000);
      wreg(DOCU_OFS_CONTROL, 32'h0000_0090);
      repeat (3) @(posedge clk);
      #1;
      chk("masked irq", {31'h0, irq}, 32'h0);
      wreg(DOCU_OFS_IRQ_EN, 32'h0000_0007);
      repeat (3) @(posedge clk);
      #1;
      chk("irq", {31'h0, irq}, 32'h1);
      wreg(DOCU_OFS_STAT_CLR, 32'h0000_0007);
      repeat (3) @(posedge clk);
      #1;
      chk("cleared irq", {31'h0, irq}, 32'h0);
   endtask
   task automatic t_stop;
      @(posedge clk);
      stop <= 1'b1;
      repeat (3) @(posedge clk);
      wreg(DOCU_OFS_CONTROL, 32'h0000_0055);
      @(posedge clk);
      stop <= 1'b0;
      repeat (3) @(posedge clk);
      rreg(DOCU_OFS_CONTROL, 32'h0000_0090);
   endtask
   task automatic tally_and_finish;
      if (errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_compare();
      t_arith();
      t_gate();
      t_stop();
      tally_and_finish();
   end
   // generous span; the sequence needs well under 2000 cycles
   initial begin
      #50000;
      errors++;
      tally_and_finish();
   end
endmodule
